/* File: rtl/i2pc_consts.svh */
// Overview of operation
// R1: writing one to bit 15 holds the serial interface in reset until cleared.
// R2: software confirms the bus is idle before clearing the soft reset bit.
// R3: checksum request bit 12 clears on checksum sent, start, stop or disable.
// R4: losing arbitration marks the running checksum as invalid.
// R5: bit 11 moves ack and checksum request to the next byte; disable clears it.
// R6: software uses bit 11 only for two-byte receptions, set before reception.
// R7: software clears ack enable only after the address-matched flag is cleared.
// R8: software sets checksum request after bit 11 while clock is stretched.
// R9: bit 10 set acknowledges each received byte; disable clears it.
// R10: master stop request bit 9 makes a stop; cleared when a stop is seen.
// R11: slave stop request releases clock and data after the current byte.
// R12: software writes nothing while a start, stop or checksum request pends.
// R13: start request bit 8 makes a start; cleared once sent or on disable.
// R14: slave stretches clock on address match or byte done unless bit 7 set.
// R15: bit 6 set acknowledges general call address 00h; clear refuses it.
// R16: bit 5 switches the checksum calculation on or off.
// R17: enable cleared mid-transfer finishes the transfer, then clears all bits.
// R18: in master mode software keeps enable set until communication ends.
// R19: software keeps reserved bits 14:13 and 4:1 at reset value.
// R20: registers accept half-word and word accesses.
// R21: after system reset all control bits read zero.
`ifndef I2PC_CONSTS_SVH
`define I2PC_CONSTS_SVH

`define I2PC_ADDR_W     8
`define I2PC_CTRL_IDX   6'h00
`define I2PC_STAT_IDX   6'h10
`define I2PC_CTRL_RST   16'h0000
`define I2PC_CTRL_WMASK 16'h9fe1

`define I2PC_B_SRST  15
`define I2PC_B_CRC   12
`define I2PC_B_APOS  11
`define I2PC_B_ACK_ENABLE 10
`define I2PC_B_STOP  9
`define I2PC_B_START 8
`define I2PC_B_NOSTR 7
`define I2PC_B_GC    6
`define I2PC_B_CRCEN 5
`define I2PC_B_EN    0

`define I2PC_RESP_OKAY   2'h0
`define I2PC_RESP_SLVERR 2'h2

`endif

/* File: rtl/i2pc_pkg.sv */
package i2pc_pkg;

  typedef enum logic [1:0] {
    I2PC_IDLE   = 2'h0,
    I2PC_ACTIVE = 2'h1,
    I2PC_DRAIN  = 2'h3
  } i2pc_mode_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } i2pc_sync_t;

  typedef struct packed {
    logic [15:0] ctrl;
    i2pc_mode_t  mode;
    logic        bd_prev;
    logic        ack_held;
    logic        crc_held;
    logic        crc_ok;
    logic        release_hold;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [15:0] rdata;
    logic [1:0]  rresp;
  } i2pc_state_t;

endpackage

/* File: rtl/i2pc_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2pc_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, rise, fall);
  modport dst (input level, rise, fall);
endinterface
`default_nettype wire

/* File: rtl/i2pc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module i2pc_pin_sync
  import i2pc_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   pin,
  i2pc_sync_if.src    out
);
  i2pc_sync_t s;
  i2pc_sync_t next_s;

  // first stage feeds only the second; edges come from the settled stages
  always_comb begin
    next_s      = s;
    next_s.meta = pin;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{meta: 1'h1, sync: 1'h1, prev: 1'h1};
    end else begin
      s <= next_s;
    end
  end

  assign out.level = s.sync;
  assign out.rise  = s.sync & ~s.prev;
  assign out.fall  = ~s.sync & s.prev;
endmodule // i2pc_pin_sync
`default_nettype wire

/* File: rtl/i2pc_primary_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "i2pc_consts.svh"
module i2pc_primary_control
  import i2pc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  input  wire logic        master_mode,
  input  wire logic        busy,
  input  wire logic        address_matched_flag,
  input  wire logic        byte_done_flag,
  input  wire logic        gc_addr_seen,
  input  wire logic        crc_byte_done,
  input  wire logic        arb_lost,
  output logic             iface_reset,
  output logic             iface_enable,
  output logic             start_request,
  output logic             stop_request,
  output logic             crc_checker_enable,
  output logic             crc_this_byte,
  output logic             crc_valid,
  output logic             ack_out,
  output logic             line_release
);

  // ********************************
  // line sampling
  // ********************************
  i2pc_sync_if scl_s ();
  i2pc_sync_if sda_s ();

  i2pc_pin_sync u_scl_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (scl_i),
    .out     (scl_s)
  );

  i2pc_pin_sync u_sda_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (sda_i),
    .out     (sda_s)
  );

  logic start_det;
  logic stop_det;
  assign start_det = sda_s.fall & scl_s.level;
  assign stop_det  = sda_s.rise & scl_s.level;

  // ********************************
  // state
  // ********************************
  i2pc_state_t s;
  i2pc_state_t next_s;

  logic        wr_now;
  logic        wr_ctrl;
  logic        en_eff;
  logic        srst;
  logic        bd_rise;
  logic [15:0] wr_val;
  logic [15:0] status;

  assign wr_now  = s.aw_got & s.w_got & ~s.bvalid;
  assign wr_ctrl = wr_now & (s.awaddr[7:2] == `I2PC_CTRL_IDX);
  assign srst    = s.ctrl[`I2PC_B_SRST];
  // a disable landing mid-transfer keeps the engine on until the drain state takes over
  assign en_eff  = (s.ctrl[`I2PC_B_EN] | (s.mode == I2PC_DRAIN)
                   | ((s.mode == I2PC_ACTIVE) & busy)) & ~srst; // R17
  assign bd_rise = byte_done_flag & ~s.bd_prev;
  assign status  = {12'h000, s.mode == I2PC_DRAIN, s.release_hold, s.crc_ok, busy};

  // half-word writes touch only their lanes; upper lanes hold no bits
  always_comb begin
    wr_val = s.ctrl;
    if (s.wstrb[0]) begin
      wr_val[7:0] = s.wdata[7:0];
    end
    if (s.wstrb[1]) begin
      wr_val[15:8] = s.wdata[15:8];
    end
    wr_val = wr_val & `I2PC_CTRL_WMASK;
  end

  always_comb begin
    next_s         = s;
    next_s.bd_prev = byte_done_flag;

    // ********************************
    // bus slave
    // ********************************
    if (awvalid && awready) begin
      next_s.aw_got = 1'h1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_got = 1'h1;
      next_s.wdata = wdata[15:0];
      next_s.wstrb = wstrb[1:0];
    end
    if (wr_now) begin
      next_s.bvalid = 1'h1;
      next_s.aw_got = 1'h0;
      next_s.w_got  = 1'h0;
      if (s.awaddr[7:2] == `I2PC_CTRL_IDX || s.awaddr[7:2] == `I2PC_STAT_IDX) begin
        next_s.bresp = `I2PC_RESP_OKAY;
      end else begin
        next_s.bresp = `I2PC_RESP_SLVERR;
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'h0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'h1;
      case (araddr[7:2])
        `I2PC_CTRL_IDX: begin
          next_s.rdata = s.ctrl;
          next_s.rresp = `I2PC_RESP_OKAY;
        end
        `I2PC_STAT_IDX: begin
          next_s.rdata = status;
          next_s.rresp = `I2PC_RESP_OKAY;
        end
        default: begin
          next_s.rdata = 16'h0000;
          next_s.rresp = `I2PC_RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'h0;
    end

    // ********************************
    // byte boundary and line release
    // ********************************
    // a byte end in the same cycle as a line condition wins the release
    if (start_det || stop_det) begin
      next_s.release_hold = 1'h0; // R11
    end
    if (bd_rise) begin
      next_s.ack_held = s.ctrl[`I2PC_B_ACK_ENABLE]; // R5
      next_s.crc_held = s.ctrl[`I2PC_B_CRC]; // R5
      if (s.ctrl[`I2PC_B_STOP] && !master_mode && en_eff) begin
        next_s.release_hold = 1'h1; // R11
      end
    end

    // arbitration loss poisons the running checksum until the next start
    if (start_det && s.ctrl[`I2PC_B_CRCEN]) begin
      next_s.crc_ok = 1'h1; // R16
    end
    if (arb_lost || !s.ctrl[`I2PC_B_CRCEN]) begin
      next_s.crc_ok = 1'h0; // R4 R16
    end

    // ********************************
    // hardware clears of request, position and ack bits
    // ********************************
    if (crc_byte_done || start_det || stop_det || !en_eff) begin
      next_s.ctrl[`I2PC_B_CRC] = 1'h0; // R3
    end
    if (stop_det) begin
      next_s.ctrl[`I2PC_B_STOP] = 1'h0; // R10
    end
    if ((start_det && master_mode) || !en_eff) begin
      next_s.ctrl[`I2PC_B_START] = 1'h0; // R13
    end
    if (!en_eff) begin
      next_s.ctrl[`I2PC_B_APOS]  = 1'h0; // R5
      next_s.ctrl[`I2PC_B_ACK_ENABLE] = 1'h0; // R9
    end

    // ********************************
    // enable sequencing
    // ********************************
    case (s.mode)
      I2PC_IDLE: begin
        if (s.ctrl[`I2PC_B_EN]) begin
          next_s.mode = I2PC_ACTIVE;
        end
      end
      I2PC_ACTIVE: begin
        if (!s.ctrl[`I2PC_B_EN]) begin
          next_s.mode = busy ? I2PC_DRAIN : I2PC_IDLE; // R17
        end
      end
      I2PC_DRAIN: begin
        if (!busy) begin
          next_s.mode = I2PC_IDLE;
          next_s.ctrl = `I2PC_CTRL_RST; // R17
        end
      end
      default: begin
        next_s.mode = I2PC_IDLE;
      end
    endcase

    // soft reset holds the engine and drops everything but itself
    if (srst) begin
      next_s.ctrl         = 16'h0000;
      next_s.ctrl[`I2PC_B_SRST] = 1'h1; // R1
      next_s.mode         = I2PC_IDLE;
      next_s.ack_held     = 1'h0;
      next_s.crc_held     = 1'h0;
      next_s.crc_ok       = 1'h0;
      next_s.release_hold = 1'h0; // R14
    end

    // a software write lands last so a new request is never lost
    if (wr_ctrl) begin
      next_s.ctrl = wr_val; // R20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0; // R21
    end else begin
      s <= next_s;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready  = ~s.w_got & ~s.bvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = ~s.rvalid;
  assign rvalid  = s.rvalid;
  assign rdata   = {16'h0000, s.rdata};
  assign rresp   = s.rresp;

  assign iface_reset        = srst; // R1
  assign iface_enable       = en_eff;
  assign start_request      = s.ctrl[`I2PC_B_START] & en_eff; // R13
  assign stop_request       = s.ctrl[`I2PC_B_STOP] & en_eff; // R10
  assign crc_checker_enable = s.ctrl[`I2PC_B_CRCEN] & en_eff; // R16
  assign crc_valid          = s.crc_ok; // R4
  assign line_release       = s.release_hold; // R11
  assign crc_this_byte      = s.ctrl[`I2PC_B_APOS] ? s.crc_held : s.ctrl[`I2PC_B_CRC]; // R5

  // general call overrides the usual ack choice for the address byte
  always_comb begin
    if (!en_eff) begin
      ack_out = 1'h0;
    end else if (gc_addr_seen) begin
      ack_out = s.ctrl[`I2PC_B_GC]; // R15
    end else if (s.ctrl[`I2PC_B_APOS]) begin
      ack_out = s.ack_held; // R5
    end else begin
      ack_out = s.ctrl[`I2PC_B_ACK_ENABLE]; // R9
    end
  end

  // open drain: only ever pull low, never drive high
  assign scl_o  = 1'h0;
  assign scl_oe = en_eff & ~master_mode & ~s.ctrl[`I2PC_B_NOSTR] & ~s.release_hold
                & (address_matched_flag | byte_done_flag); // R14

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_clear: assert property (stop_det && !wr_ctrl |=> !s.ctrl[`I2PC_B_STOP]) // R10
    else $error("stop request survived a detected stop");
  a_start_clear: assert property (start_det && master_mode && !wr_ctrl
                                  |=> !s.ctrl[`I2PC_B_START]) // R13
    else $error("start request survived a sent start");
  a_crc_clear: assert property ((crc_byte_done || stop_det) && !wr_ctrl
                                |=> !s.ctrl[`I2PC_B_CRC]) // R3
    else $error("checksum request survived its clearing event");
  a_arb_crc: assert property (arb_lost |=> !crc_valid) // R4
    else $error("checksum still valid after arbitration loss");
  a_srst_hold: assert property (srst && !wr_ctrl |=> iface_reset && !s.ctrl[`I2PC_B_NOSTR]
                                && !iface_enable) // R1
    else $error("soft reset did not hold the interface");
  a_drain_end: assert property (s.mode == I2PC_DRAIN && !busy && !wr_ctrl && !srst
                                |=> s.ctrl == 16'h0000 && s.mode == I2PC_IDLE) // R17
    else $error("disable did not clear the control bits");
  a_drain_wait: assert property (s.mode == I2PC_ACTIVE && !s.ctrl[`I2PC_B_EN] && busy
                                 && !srst && !wr_ctrl
                                 |-> iface_enable ##1 iface_enable && s.mode == I2PC_DRAIN) // R17
    else $error("disable cut off a transfer in progress");
  a_gc_ack: assert property (en_eff && gc_addr_seen |-> ack_out == s.ctrl[`I2PC_B_GC]) // R15
    else $error("general call answer ignores its enable");
  a_stretch_hold: assert property ($rose(address_matched_flag) && en_eff && !master_mode
                                   && !s.ctrl[`I2PC_B_NOSTR] && !s.release_hold
                                   |-> scl_oe) // R14
    else $error("clock not stretched on address match");
  a_write_resp: assert property (wr_now |=> bvalid ##0 !awready && !wready) // R20
    else $error("write answer missing");
  a_read_resp: assert property (arvalid && arready |=> rvalid && !arready) // R20
    else $error("read answer missing");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) // R20
    else $error("read answer changed before it was taken");
  a_reset_zero: assert property ($rose(aresetn) |-> s.ctrl == `I2PC_CTRL_RST) // R21
    else $error("control bits not zero after reset");

endmodule // i2pc_primary_control
`default_nettype wire

/* File: tb/i2pc_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// remote party on the two-wire bus
// ****************************************************
module i2pc_bus_model (
  input  wire logic scl_oe,
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_low = 1'h0;
  logic sda_low = 1'h0;
  // pull-ups: a released line goes high, never keeps an old value
  assign scl_line = !(scl_oe || scl_low);
  assign sda_line = !sda_low;
  // data falls while the clock stands high
  task automatic frame_start();
    sda_low = 1'h1;
    #160 scl_low = 1'h1;
    #160;
  endtask
  // 320 ns clock; waits while the slave stretches it
  task automatic pulses(input int n);
    repeat (n) begin
      scl_low = 1'h0;
      for (int k = 0; k < 64 && !scl_line; k++) #40;
      #160 scl_low = 1'h1;
      #160;
    end
  endtask
  // data rises while the clock stands high
  task automatic frame_stop();
    sda_low = 1'h1;
    #160 scl_low = 1'h0;
    #160 sda_low = 1'h0;
    #160;
  endtask
endmodule // i2pc_bus_model
`default_nettype wire

/* File: tb/i2pc_primary_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module i2pc_primary_control_test;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, scl_line, sda_line, scl_oe;
  logic [1:0]  bresp, rresp;
  logic        master_mode = 1'h0, busy = 1'h0, address_matched_flag = 1'h0;
  logic        byte_done_flag = 1'h0, gc_addr_seen = 1'h0, crc_byte_done = 1'h0;
  logic        arb_lost = 1'h0;
  logic        iface_reset, iface_enable, start_request, stop_request, crc_checker_enable;
  logic        crc_this_byte, crc_valid, ack_out, line_release;
  int          err_total = 0, n_checks = 0, cyc = 0;

  i2pc_primary_control dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_i(scl_line), .scl_o(), .scl_oe, .sda_i(sda_line), .master_mode,
    .busy, .address_matched_flag, .byte_done_flag, .gc_addr_seen, .crc_byte_done, .arb_lost,
    .iface_reset, .iface_enable, .start_request, .stop_request, .crc_checker_enable,
    .crc_this_byte, .crc_valid, .ack_out, .line_release);
  i2pc_bus_model bus_u (.scl_oe(scl_oe), .scl_line(scl_line), .sda_line(sda_line));

  always #20 aclk = ~aclk;
  // the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  // ****************************************************
  // bus tasks and comparison
  // ****************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic ck1(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic s_reset();
    rc(8'h00, 32'h0);
    rc(8'h40, 32'h0);
    rc(8'h08, 32'h0, 2'h2);
    wr(8'h08, 32'h0000_ffff, 4'hf, 2'h2);
    ck1("iface_enable", iface_enable, 1'h0);
  endtask
  task automatic s_fields();
    wr(8'h00, 32'ha5a5_0461, 4'hf);
    rc(8'h00, 32'h0000_0461);
    @(negedge aclk);
    ck1("crc_checker_enable", crc_checker_enable, 1'h1);
    ck1("ack_out", ack_out, 1'h1);
    @(posedge aclk);
    gc_addr_seen <= 1'h1;
    @(negedge aclk);
    ck1("ack_out_gc_on", ack_out, 1'h1);
    wr(8'h00, 32'h0000_0021, 4'h1);
    rc(8'h00, 32'h0000_0421);
    ck1("ack_out_gc_off", ack_out, 1'h0);
    @(posedge aclk);
    gc_addr_seen <= 1'h0;
    address_matched_flag <= 1'h1;
    @(negedge aclk);
    ck1("scl_oe_stretch", scl_oe, 1'h1);
    wr(8'h00, 32'h0000_00a1, 4'h1);
    @(negedge aclk);
    ck1("scl_oe_free", scl_oe, 1'h0);
    @(posedge aclk);
    address_matched_flag <= 1'h0;
    wr(8'h00, 32'h0000_0021, 4'h3);
    @(negedge aclk);
    ck1("ack_out_off", ack_out, 1'h0);
  endtask
  task automatic s_start();
    @(posedge aclk);
    master_mode <= 1'h1;
    wr(8'h00, 32'h0000_1121, 4'h3);
    @(negedge aclk);
    ck1("start_request", start_request, 1'h1);
    bus_u.frame_start();
    rc(8'h00, 32'h0000_0021);
    ck1("crc_valid", crc_valid, 1'h1);
    @(posedge aclk);
    arb_lost <= 1'h1;
    @(posedge aclk);
    arb_lost <= 1'h0;
    @(negedge aclk);
    ck1("crc_valid_lost", crc_valid, 1'h0);
    wr(8'h00, 32'h0000_1021, 4'h3);
    @(posedge aclk);
    crc_byte_done <= 1'h1;
    @(posedge aclk);
    crc_byte_done <= 1'h0;
    rc(8'h00, 32'h0000_0021);
    bus_u.pulses(9);
    wr(8'h00, 32'h0000_0221, 4'h3);
    @(negedge aclk);
    ck1("stop_request", stop_request, 1'h1);
    bus_u.frame_stop();
    rc(8'h00, 32'h0000_0021);
  endtask
  task automatic s_slave();
    @(posedge aclk);
    master_mode <= 1'h0;
    bus_u.frame_start();
    wr(8'h00, 32'h0000_0201, 4'h3);
    @(posedge aclk);
    byte_done_flag <= 1'h1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    ck1("line_release", line_release, 1'h1);
    ck1("scl_oe_release", scl_oe, 1'h0);
    @(posedge aclk);
    byte_done_flag <= 1'h0;
    bus_u.frame_stop();
    rc(8'h00, 32'h0000_0001);
    // ack and checksum decided for the byte after the one now done
    wr(8'h00, 32'h0000_0c01, 4'h3);
    @(posedge aclk);
    address_matched_flag <= 1'h1;
    wr(8'h00, 32'h0000_1c01, 4'h3);
    @(posedge aclk);
    address_matched_flag <= 1'h0;
    byte_done_flag <= 1'h1;
    @(posedge aclk);
    byte_done_flag <= 1'h0;
    crc_byte_done <= 1'h1;
    @(posedge aclk);
    crc_byte_done <= 1'h0;
    @(negedge aclk);
    ck1("crc_this_byte_held", crc_this_byte, 1'h1);
    wr(8'h00, 32'h0000_0801, 4'h3);
    @(negedge aclk);
    ck1("ack_out_held", ack_out, 1'h1);
    @(posedge aclk);
    byte_done_flag <= 1'h1;
    @(posedge aclk);
    byte_done_flag <= 1'h0;
    @(negedge aclk);
    ck1("ack_out_next", ack_out, 1'h0);
    ck1("crc_this_byte_next", crc_this_byte, 1'h0);
  endtask
  task automatic s_disable();
    wr(8'h00, 32'h0000_0c21, 4'h3);
    @(posedge aclk);
    busy <= 1'h1;
    wr(8'h00, 32'h0000_0c20, 4'h3);
    @(negedge aclk);
    ck1("iface_enable_drain", iface_enable, 1'h1);
    rc(8'h40, 32'h0000_0009);
    @(posedge aclk);
    busy <= 1'h0;
    repeat (2) @(posedge aclk);
    rc(8'h00, 32'h0);
    ck1("iface_enable_idle", iface_enable, 1'h0);
    wr(8'h00, 32'h0000_00a1, 4'h3);
    wr(8'h00, 32'h0000_80a1, 4'h3);
    @(negedge aclk);
    ck1("iface_reset", iface_reset, 1'h1);
    rc(8'h00, 32'h0000_8000);
    ck1("iface_enable_srst", iface_enable, 1'h0);
    wr(8'h00, 32'h0, 4'h3);
    @(negedge aclk);
    ck1("iface_reset_off", iface_reset, 1'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    s_reset();
    s_fields();
    s_start();
    s_slave();
    s_disable();
    stop_test();
  end
endmodule // i2pc_primary_control_test
`default_nettype wire
